//--- logic/ssc_cyclic.sv
// Purpose: cyclic sense timer, enable window at the start of each period
// Assumes: run is synchronous to clock
// Notes:   period restarts from zero whenever run rises
`timescale 1ns/1ps
module ssc_cyclic #(
   parameter int PERIOD = ssc_pkg::CYC_PERIOD_CYCLES,
   parameter int ON     = ssc_pkg::CYC_ON_CYCLES
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // control and phase
   input  wire logic run,
   output logic      on_phase
);

   localparam logic [ssc_pkg::CNT_W-1:0] LAST = ssc_pkg::CNT_W'(PERIOD - 1);
   localparam logic [ssc_pkg::CNT_W-1:0] WIN  = ssc_pkg::CNT_W'(ON);

   logic [ssc_pkg::CNT_W-1:0] cnt;

   // -----------------------------------------------------------------
   // period counter
   // -----------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt <= '0;
      end else if (!run || cnt == LAST) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

   // window flag; a window longer than the period keeps the switch on
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         on_phase <= 1'b0;
      end else begin
         on_phase <= run && (cnt < WIN);
      end
   end

endmodule

//--- logic/ssc_pkg.sv
// Purpose: shared constants and types for the supply switch control block
// Assumes: 200 MHz system clock
// Notes:   register offsets are byte addresses on a 32-bit Avalon-MM slave
package ssc_pkg;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_MHZ           = 200;
   localparam int RESET_TIME_US     = 1000;                 // reset pulse, 1 ms
   localparam int RESET_CYCLES      = RESET_TIME_US * CLK_MHZ;
   localparam int CYC_PERIOD_MS     = 32;                   // shortest sense period
   localparam int CYC_PERIOD_CYCLES = CYC_PERIOD_MS * 1000 * CLK_MHZ;
   localparam int CYC_ON_US         = 1000;                 // enable window
   localparam int CYC_ON_CYCLES     = CYC_ON_US * CLK_MHZ;
   localparam int CNT_W             = 32;

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam logic [4:0] OFS_CTRL    = 5'h00;
   localparam logic [4:0] OFS_MASK    = 5'h04;
   localparam logic [4:0] OFS_RST_SRC = 5'h08;
   localparam logic [4:0] OFS_OTEMP   = 5'h0C;
   localparam logic [4:0] OFS_SUPPLY  = 5'h10;
   localparam logic [4:0] OFS_STATE   = 5'h14;

   // control fields
   localparam int CTRL_MODE_LSB    = 0;   // two bits
   localparam int CTRL_BAT_NORM    = 2;
   localparam int CTRL_BAT_STBY    = 3;
   localparam int CTRL_BAT_CYC     = 4;
   localparam int CTRL_PER_RESTART = 5;   // write one, reads zero
   localparam logic [1:0] MODE_NORMAL  = 2'h0;
   localparam logic [1:0] MODE_STANDBY = 2'h1;
   localparam logic [1:0] MODE_SLEEP   = 2'h2;
   localparam logic [1:0] MODE_EMERG   = 2'h3;

   // sticky flag positions, shared by flag and mask vectors
   localparam int FLG_MCU_UV   = 0;
   localparam int FLG_MCU_WARN = 1;
   localparam int FLG_MCU_SHUT = 2;
   localparam int FLG_PER_WARN = 3;
   localparam int FLG_PER_SHUT = 4;
   localparam int FLG_PER_UV   = 5;
   localparam int FLG_BAT_OT   = 6;
   localparam int NFLAGS       = 7;
   localparam logic [NFLAGS-1:0] MASK_RESET = 7'h00;
   localparam logic [3:0]        CFG_RESET  = 4'h0;

   typedef enum logic [4:0] {
      M_START   = 5'h01,
      M_NORMAL  = 5'h02,
      M_STANDBY = 5'h04,
      M_SLEEP   = 5'h08,
      M_EMERG   = 5'h10
   } ssc_mode_t;

   // analog comparator outputs, all active high
   typedef struct packed {
      logic bat_present;
      logic bat_ot;
      logic per_ot_shut;
      logic per_ot_warn;
      logic per_uv;
      logic mcu_ot_shut;
      logic mcu_ot_warn;
      logic mcu_uv;
   } ssc_cmp_t;

endpackage

//--- logic/ssc_sync.sv
// Purpose: two-flop synchroniser for a vector of unrelated levels
// Assumes: each bit is an independent slow level
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module ssc_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         rst,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   // -----------------------------------------------------------------
   // per-bit double flop
   // -----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta;
         logic stage2;
         // bits are not coherent with each other, which is fine for levels
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               meta   <= 1'b0;
               stage2 <= 1'b0;
            end else begin
               meta   <= d[i];
               stage2 <= meta;
            end
         end
         // one driver per bit keeps the output a single-source vector
         assign q[i] = stage2;
      end
   endgenerate

endmodule

//--- logic/ssc_top.sv
// Purpose: on/off control of the mcu and peripheral regulators and battery switch
// Assumes: comparator inputs are asynchronous levels; Avalon-MM master on clock
// Notes:   status flags clear on read of their register; mode is software set, except the return to startup on mcu undervoltage
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - undervoltage drives mcu reset low 1 ms
// - undervoltage reset sets reset source flag
// - mcu pre-warning sets flag, maskable interrupt
// - mcu shut-off sets flag, interrupt, regulator off
// - mcu regulator returns once below pre-warning
// - mcu regulator on: startup, normal, standby, reset
// - mcu off: sleep, emergency, overtemp, no battery
// - peripheral on only in normal, not overheated
// - peripheral undervoltage sets supply status flag
// - peripheral pre-warning sets flag, maskable interrupt
// - peripheral shut-off sets flag, regulator off
// - peripheral restarts only by host command
// - peripheral off outside normal or mcu off
// - switch overtemp sets flag, off, auto restore
// - switch on by config normal, standby, sense
// - switch off by config, sense disable time
// - switch off: startup, mcu fault, peripheral shutoff
module ssc_top #(
   parameter int RESET_CYCLES = ssc_pkg::RESET_CYCLES,
   parameter int CYC_PERIOD   = ssc_pkg::CYC_PERIOD_CYCLES,
   parameter int CYC_ON       = ssc_pkg::CYC_ON_CYCLES
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // avalon-mm slave
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // analog comparators
   input  wire ssc_pkg::ssc_cmp_t cmp,
   // supply enables and mcu lines
   output logic             mcu_regulator_en,
   output logic             peripheral_regulator_en,
   output logic             battery_switch_en,
   output logic             mcu_reset_out_low,
   output logic             irq
);
   localparam logic [ssc_pkg::CNT_W-1:0] RST_LOAD = ssc_pkg::CNT_W'(RESET_CYCLES);
   ssc_pkg::ssc_cmp_t         cmp_s;
   ssc_pkg::ssc_mode_t        mode;
   logic [3:0]                cfg;
   logic [ssc_pkg::NFLAGS-1:0] flags;
   logic [ssc_pkg::NFLAGS-1:0] mask;
   logic [ssc_pkg::NFLAGS-1:0] set_v;
   logic [ssc_pkg::NFLAGS-1:0] clr_v;
   logic [ssc_pkg::CNT_W-1:0] rst_cnt;
   logic [31:0]               next_readdata;
   logic                      mcu_ot_off;
   logic                      per_ot_off;
   logic                      in_reset;
   logic                      cyc_on;
   logic                      acc;
   logic                      wr_ctrl;
   logic                      per_restart;
   logic                      mcu_fault;
   logic                      next_mcu_en;
   logic                      next_per_en;
   logic                      next_bat_en;

   // -----------------------------------------------------------------
   // input synchronisation and cyclic sense timer
   // -----------------------------------------------------------------
   ssc_sync #(
      .W ($bits(ssc_pkg::ssc_cmp_t))
   ) u_sync (
      .clock (clock),
      .rst   (rst),
      .d     (cmp),
      .q     (cmp_s)
   );

   ssc_cyclic #(
      .PERIOD (CYC_PERIOD),
      .ON     (CYC_ON)
   ) u_cyc (
      .clock    (clock),
      .rst      (rst),
      .run      (mode == ssc_pkg::M_SLEEP && cfg[ssc_pkg::CTRL_BAT_CYC - ssc_pkg::CTRL_BAT_NORM]),
      .on_phase (cyc_on)
   );

   // -----------------------------------------------------------------
   // avalon-mm handshake
   // -----------------------------------------------------------------
   // one wait cycle gives read data a full cycle to settle
   assign acc         = (read || write) && !waitrequest;
   assign wr_ctrl     = acc && write && address == ssc_pkg::OFS_CTRL && byteenable[0];
   assign per_restart = wr_ctrl && writedata[ssc_pkg::CTRL_PER_RESTART];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      next_readdata = 32'h0000_0000;
      unique case (address)
         ssc_pkg::OFS_CTRL:    next_readdata[4:0] = {cfg[2:0], mode_code(mode)};
         ssc_pkg::OFS_MASK:    next_readdata[6:0] = mask;
         ssc_pkg::OFS_RST_SRC: next_readdata[0]   = flags[ssc_pkg::FLG_MCU_UV];
         ssc_pkg::OFS_OTEMP:   next_readdata[3:0] = flags[4:1];
         ssc_pkg::OFS_SUPPLY:  next_readdata[1:0] = flags[6:5];
         ssc_pkg::OFS_STATE:   next_readdata[10:0] = {per_ot_off, mcu_ot_off, in_reset,
                                  battery_switch_en, peripheral_regulator_en,
                                  mcu_regulator_en, mode};
         default:              next_readdata = 32'h0000_0000;
      endcase
   end

   // snapshot taken in the wait cycle, stands through the accept edge
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         readdata <= 32'h0000_0000;
      end else if (read && waitrequest) begin
         readdata <= next_readdata;
      end
   end

   function automatic logic [1:0] mode_code(input ssc_pkg::ssc_mode_t m);
      unique case (m)
         ssc_pkg::M_STANDBY: mode_code = ssc_pkg::MODE_STANDBY;
         ssc_pkg::M_SLEEP:   mode_code = ssc_pkg::MODE_SLEEP;
         ssc_pkg::M_EMERG:   mode_code = ssc_pkg::MODE_EMERG;
         default:            mode_code = ssc_pkg::MODE_NORMAL;
      endcase
   endfunction

   // -----------------------------------------------------------------
   // configuration registers
   // -----------------------------------------------------------------
   // undervoltage reset drops back to startup pending, like a power-on
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mode <= ssc_pkg::M_START;
      end else if (cmp_s.mcu_uv) begin
         mode <= ssc_pkg::M_START;
      end else if (wr_ctrl) begin
         unique case (writedata[ssc_pkg::CTRL_MODE_LSB +: 2])
            ssc_pkg::MODE_NORMAL:  mode <= ssc_pkg::M_NORMAL;
            ssc_pkg::MODE_STANDBY: mode <= ssc_pkg::M_STANDBY;
            ssc_pkg::MODE_SLEEP:   mode <= ssc_pkg::M_SLEEP;
            ssc_pkg::MODE_EMERG:   mode <= ssc_pkg::M_EMERG;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cfg <= ssc_pkg::CFG_RESET;
      end else if (wr_ctrl) begin
         cfg <= {1'b0, writedata[ssc_pkg::CTRL_BAT_CYC:ssc_pkg::CTRL_BAT_NORM]};
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mask <= ssc_pkg::MASK_RESET;
      end else if (acc && write && address == ssc_pkg::OFS_MASK && byteenable[0]) begin
         mask <= writedata[ssc_pkg::NFLAGS-1:0];
      end
   end

   // -----------------------------------------------------------------
   // mcu reset pulse
   // -----------------------------------------------------------------
   // held while undervoltage lasts, then counted out after release
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rst_cnt <= RST_LOAD;
      end else if (cmp_s.mcu_uv) begin
         rst_cnt <= RST_LOAD;
      end else if (rst_cnt != '0) begin
         rst_cnt <= rst_cnt - 1'b1;
      end
   end
   assign in_reset = rst_cnt != '0;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mcu_reset_out_low <= 1'b0;
      end else begin
         mcu_reset_out_low <= !in_reset && !cmp_s.mcu_uv;
      end
   end

   // -----------------------------------------------------------------
   // thermal latches
   // -----------------------------------------------------------------
   // mcu side restores itself once below the pre-warning level
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mcu_ot_off <= 1'b0;
      end else if (cmp_s.mcu_ot_shut) begin
         mcu_ot_off <= 1'b1;
      end else if (!cmp_s.mcu_ot_warn) begin
         mcu_ot_off <= 1'b0;
      end
   end

   // peripheral side never restarts by itself; shut-off beats restart
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         per_ot_off <= 1'b0;
      end else if (cmp_s.per_ot_shut) begin
         per_ot_off <= 1'b1;
      end else if (per_restart) begin
         per_ot_off <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // supply enables
   // -----------------------------------------------------------------
   // sleep is a commanded off, not a fault, so the switch may still sense
   assign mcu_fault = mcu_ot_off || !cmp_s.bat_present;
   always_comb begin
      next_mcu_en = !mcu_fault && (in_reset || mode == ssc_pkg::M_START ||
                    mode == ssc_pkg::M_NORMAL || mode == ssc_pkg::M_STANDBY);
      next_per_en = next_mcu_en && mode == ssc_pkg::M_NORMAL && !in_reset &&
                    !per_ot_off && !cmp_s.per_ot_shut;
      next_bat_en = !mcu_fault && !per_ot_off && !cmp_s.bat_ot &&
                    ((mode == ssc_pkg::M_NORMAL && cfg[0]) ||
                     (mode == ssc_pkg::M_STANDBY && cfg[1]) ||
                     (mode == ssc_pkg::M_SLEEP && cfg[2] && cyc_on));
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mcu_regulator_en        <= 1'b0;
         peripheral_regulator_en <= 1'b0;
         battery_switch_en       <= 1'b0;
      end else begin
         mcu_regulator_en        <= next_mcu_en;
         peripheral_regulator_en <= next_per_en;
         battery_switch_en       <= next_bat_en;
      end
   end

   // -----------------------------------------------------------------
   // sticky flags and interrupt
   // -----------------------------------------------------------------
   assign set_v = {cmp_s.bat_ot, cmp_s.per_uv, cmp_s.per_ot_shut, cmp_s.per_ot_warn,
                   cmp_s.mcu_ot_shut, cmp_s.mcu_ot_warn, cmp_s.mcu_uv};
   // only the bits the host actually saw are cleared, so nothing is lost
   always_comb begin
      clr_v = '0;
      if (acc && read) begin
         unique case (address)
            ssc_pkg::OFS_RST_SRC: clr_v[0]   = readdata[0];
            ssc_pkg::OFS_OTEMP:   clr_v[4:1] = readdata[3:0];
            ssc_pkg::OFS_SUPPLY:  clr_v[6:5] = readdata[1:0];
            default:              clr_v      = '0;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flags <= '0;
      end else begin
         flags <= (flags & ~clr_v) | set_v;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flags & mask);
      end
   end

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_rst_low;
      cmp_s.mcu_uv |=> !mcu_reset_out_low [*2];
   endproperty
   a_rst_low: assert property (p_rst_low) else $error("reset not held low");
   property p_rst_flag;
      cmp_s.mcu_uv |=> flags[ssc_pkg::FLG_MCU_UV];
   endproperty
   a_rst_flag: assert property (p_rst_flag) else $error("reset source flag missing");
   property p_mcu_warn;
      cmp_s.mcu_ot_warn |=> flags[ssc_pkg::FLG_MCU_WARN]
         ##1 (irq || !$past(mask[ssc_pkg::FLG_MCU_WARN]));
   endproperty
   a_mcu_warn: assert property (p_mcu_warn) else $error("mcu warning flag missing");
   property p_mcu_shut;
      cmp_s.mcu_ot_shut |=> mcu_ot_off ##1 !mcu_regulator_en;
   endproperty
   a_mcu_shut: assert property (p_mcu_shut) else $error("mcu regulator not shut off");
   property p_mcu_back;
      mcu_ot_off && !cmp_s.mcu_ot_warn && !cmp_s.mcu_ot_shut |=> !mcu_ot_off;
   endproperty
   a_mcu_back: assert property (p_mcu_back) else $error("mcu regulator not restored");
   property p_mcu_sleep;
      mode == ssc_pkg::M_SLEEP && !in_reset |=> !mcu_regulator_en;
   endproperty
   a_mcu_sleep: assert property (p_mcu_sleep) else $error("mcu regulator on in sleep");
   property p_per_mode;
      peripheral_regulator_en |-> $past(mode) == ssc_pkg::M_NORMAL && $past(mcu_ot_off) == 1'b0;
   endproperty
   a_per_mode: assert property (p_per_mode) else $error("peripheral on outside normal");
   property p_per_hold;
      per_ot_off && !per_restart |=> per_ot_off;
   endproperty
   a_per_hold: assert property (p_per_hold) else $error("peripheral restarted alone");
   property p_bat_off;
      per_ot_off || mode == ssc_pkg::M_START |=> !battery_switch_en;
   endproperty
   a_bat_off: assert property (p_bat_off) else $error("battery switch not forced off");
   property p_irq;
      irq |-> $past(|(flags & mask));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt without masked flag");

   c_rst_done: cover property ($rose(mcu_reset_out_low));
   c_per_restart: cover property (per_ot_off ##1 !per_ot_off);
   c_cyc_on: cover property (mode == ssc_pkg::M_SLEEP && battery_switch_en);
   c_irq: cover property ($rose(irq));

endmodule

//--- verification/ssc_host.sv
// Purpose: microcontroller side model, avalon-mm master on the register port
// Assumes: the slave answers within 50 cycles
// Notes:   a request is held until waitrequest is seen low at a rising edge
`timescale 1ns/1ps
module ssc_host (
   // clock
   input  wire logic        clock,
   // avalon-mm master
   output logic      [4:0]  address,
   output logic             read,
   output logic             write,
   output logic      [3:0]  byteenable,
   output logic      [31:0] writedata,
   input  wire logic [31:0] readdata,
   input  wire logic        waitrequest
);
   int tmo = 0;   // accesses that ran out of patience

   // bus idle from time zero
   initial begin
      address = 5'h00;
      read = 1'b0;
      write = 1'b0;
      byteenable = 4'h0;
      writedata = 32'h0;
   end

   // one access; sampled values are those from before the edge's own updates
   task automatic xfer(input logic rd, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clock);
      address <= a;
      writedata <= d;
      byteenable <= 4'hF;
      read <= rd;
      write <= !rd;
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      q = readdata;
      if (n >= 50) tmo++;
      read <= 1'b0;
      write <= 1'b0;
   endtask
endmodule

//--- verification/ssc_top_bench.sv
// Purpose: self-checking bench for the supply switch control block
// Assumes: shortened counts: reset 20, sense period 40, enable window 10
// Notes:   comparator changes are given six cycles to reach the outputs
`timescale 1ns/1ps
module ssc_top_bench;
   logic              clock, rst, read, write, waitrequest, irq;
   logic [4:0]        address;
   logic [3:0]        byteenable;
   logic [31:0]       writedata, readdata, q;
   logic              mcu_regulator_en, peripheral_regulator_en, battery_switch_en;
   logic              mcu_reset_out_low;
   ssc_pkg::ssc_cmp_t cmp;
   int                bad_count = 0;
   int                n_tests = 0;

   // 200 MHz clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   ssc_top #(.RESET_CYCLES(20), .CYC_PERIOD(40), .CYC_ON(10)) DUT (
      .clock, .rst, .address, .read, .write, .byteenable, .writedata, .readdata,
      .waitrequest, .cmp, .mcu_regulator_en, .peripheral_regulator_en,
      .battery_switch_en, .mcu_reset_out_low, .irq);
   ssc_host host (.clock, .address, .read, .write, .byteenable, .writedata,
      .readdata, .waitrequest);

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic chkw(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkb(input string nm, input logic e, input logic g);
      chkw(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic en3(input logic [2:0] e);
      chkw("mcu per switch", {29'h0, e},
           {29'h0, mcu_regulator_en, peripheral_regulator_en, battery_switch_en});
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      host.xfer(1'b0, a, d, q);
      if (host.tmo != 0) test_done;
      settle(4);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
      host.xfer(1'b1, a, 32'h0, q);
      if (host.tmo != 0) test_done;
      chkw(nm, e, q);
   endtask
   task automatic test_done;
      bad_count += host.tmo;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_modes;
      settle(5);
      chkb("reset out", 1'b0, mcu_reset_out_low);
      en3(3'b100);
      settle(25);
      chkb("reset out", 1'b1, mcu_reset_out_low);
      wr(5'h00, 32'h04);
      en3(3'b111);
      wr(5'h00, 32'h00);
      en3(3'b110);
      wr(5'h00, 32'h09);
      en3(3'b101);
      rd(5'h00, 32'h09, "ctrl");
      rd(5'h14, 32'hA4, "state");
      rd(5'h18, 32'h0, "unmapped");
      $display("mode test done");
   endtask
   task automatic t_mcu_hot;
      wr(5'h00, 32'h04);
      wr(5'h04, 32'h04);
      rd(5'h04, 32'h04, "mask");
      @(posedge clock);
      cmp.mcu_ot_warn <= 1'b1;
      cmp.mcu_ot_shut <= 1'b1;
      settle(6);
      en3(3'b000);
      chkb("irq", 1'b1, irq);
      @(posedge clock);
      cmp.mcu_ot_shut <= 1'b0;
      settle(6);
      chkb("mcu on", 1'b0, mcu_regulator_en);
      @(posedge clock);
      cmp.mcu_ot_warn <= 1'b0;
      settle(6);
      en3(3'b111);
      rd(5'h0C, 32'h3, "otemp");
      settle(3);
      chkb("irq", 1'b0, irq);
      $display("mcu thermal test done");
   endtask
   task automatic t_per_hot;
      @(posedge clock);
      cmp.per_ot_warn <= 1'b1;
      cmp.per_ot_shut <= 1'b1;
      settle(6);
      en3(3'b100);
      @(posedge clock);
      cmp.per_ot_warn <= 1'b0;
      cmp.per_ot_shut <= 1'b0;
      settle(6);
      en3(3'b100);
      rd(5'h0C, 32'hC, "otemp");
      wr(5'h00, 32'h24);
      en3(3'b111);
      $display("peripheral thermal test done");
   endtask
   task automatic t_supply;
      wr(5'h04, 32'h20);
      @(posedge clock);
      cmp.per_uv <= 1'b1;
      cmp.bat_ot <= 1'b1;
      settle(6);
      en3(3'b110);
      chkb("irq", 1'b1, irq);
      @(posedge clock);
      cmp.per_uv <= 1'b0;
      cmp.bat_ot <= 1'b0;
      settle(6);
      en3(3'b111);
      chkb("irq", 1'b1, irq);
      rd(5'h10, 32'h3, "supply");
      settle(3);
      chkb("irq", 1'b0, irq);
      $display("supply flag test done");
   endtask
   task automatic t_sleep;
      int n;
      n = 0;
      wr(5'h00, 32'h12);
      en3(3'b001);
      repeat (80) begin
         @(posedge clock);
         n += int'(battery_switch_en === 1'b1);
      end
      chkw("sense window", 32'h0000_0014, n);
      wr(5'h00, 32'h03);
      en3(3'b000);
      wr(5'h00, 32'h04);
      en3(3'b111);
      @(posedge clock);
      cmp.bat_present <= 1'b0;
      settle(6);
      en3(3'b000);
      @(posedge clock);
      cmp.bat_present <= 1'b1;
      settle(6);
      $display("sleep and supply loss test done");
   endtask
   task automatic t_undervolt;
      @(posedge clock);
      cmp.mcu_uv <= 1'b1;
      settle(6);
      chkb("reset out", 1'b0, mcu_reset_out_low);
      chkb("mcu on", 1'b1, mcu_regulator_en);
      @(posedge clock);
      cmp.mcu_uv <= 1'b0;
      settle(10);
      chkb("reset out", 1'b0, mcu_reset_out_low);
      settle(20);
      chkb("reset out", 1'b1, mcu_reset_out_low);
      rd(5'h08, 32'h1, "reset source");
      $display("undervoltage test done");
   endtask

   // hang guard
   initial begin
      repeat (4000) @(posedge clock);
      bad_count++;
      test_done;
   end

   // main sequence; battery present before reset is released
   initial begin
      rst = 1'b1;
      cmp = 8'h80;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      t_modes;
      t_mcu_hot;
      t_per_hot;
      t_supply;
      t_sleep;
      t_undervolt;
      test_done;
   end
endmodule
